// File: reference_detect_diagnostics.sv
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
// Functional notes
// - check only when enabled and external reference
// - flag below 0.7 V or open input
// - flag also raises status error bit
// - results forced all ones while flagged
// - flagged calibration keeps old coefficient
// - standby exit may flag; read clears
// - test selection routes internal 20 mV source
// - reference and supplies selectable as inputs
// - error flag sticky until error read
module reference_detect_diagnostics #(
  parameter int DATA_W = 24,
  parameter int MV_W = 12
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // reference sense
  input wire logic [MV_W-1:0] ref_diff_mv,
  input wire logic reference_input_positive_open,
  input wire logic reference_input_negative_open,
  input wire logic standby_exit,
  // converter core
  input wire logic conv_valid,
  input wire logic [DATA_W-1:0] conv_data,
  input wire logic cal_done,
  input wire logic cal_is_gain,
  input wire logic [DATA_W-1:0] cal_coef,
  // input routing and status error
  output logic [2:0] input_select,
  output logic test_signal_positive,
  output logic test_signal_negative,
  output logic status_err
);
  logic [31:0] ctrl;
  logic reference_missing_flag;
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] offset_coef;
  logic [DATA_W-1:0] gain_coef;
  logic fault;
  logic check_on;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic do_read;
  logic err_read;
  logic [2:0] sel;

  assign check_on = ctrl[refdet_pkg::CTRL_CHECK_EN_BIT] &&
                    ctrl[refdet_pkg::CTRL_EXT_REF_BIT];
  assign sel = ctrl[refdet_pkg::CTRL_INPUT_SEL_LSB +: refdet_pkg::INPUT_SEL_W];

  ref_monitor #(.MV_W(MV_W)) u_mon (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .check_on(check_on),
    .ref_diff_mv(ref_diff_mv),
    .reference_input_positive_open(reference_input_positive_open),
    .reference_input_negative_open(reference_input_negative_open),
    .fault(fault)
  );

  // write channel capture: address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) w_held <= 1'b0;
    end
  end

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign err_read = do_read && (s_axi_araddr == refdet_pkg::ERROR_OFFSET);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (ce) begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // control register and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= refdet_pkg::CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= refdet_pkg::RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        if (aw_addr == refdet_pkg::CTRL_OFFSET) begin
          for (int i = 0; i < 4; i++)
            if (w_strb[i]) ctrl[i*8 +: 8] <= w_data[i*8 +: 8];
          s_axi_bresp <= refdet_pkg::RESP_OKAY;
        end else if (aw_addr == refdet_pkg::ERROR_OFFSET ||
                     aw_addr == refdet_pkg::STATUS_OFFSET ||
                     aw_addr == refdet_pkg::RESULT_OFFSET ||
                     aw_addr == refdet_pkg::OFFSET_COEF_OFFSET ||
                     aw_addr == refdet_pkg::GAIN_COEF_OFFSET) begin
          s_axi_bresp <= refdet_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= refdet_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: one outstanding read, answer one cycle after acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= refdet_pkg::RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= !s_axi_rvalid && !do_read;
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= refdet_pkg::RESP_OKAY;
        if (s_axi_araddr == refdet_pkg::CTRL_OFFSET) s_axi_rdata <= ctrl;
        else if (s_axi_araddr == refdet_pkg::ERROR_OFFSET)
          s_axi_rdata <= {31'h0, reference_missing_flag};
        else if (s_axi_araddr == refdet_pkg::STATUS_OFFSET)
          s_axi_rdata <= {31'h0, status_err};
        else if (s_axi_araddr == refdet_pkg::RESULT_OFFSET)
          s_axi_rdata <= 32'(result);
        else if (s_axi_araddr == refdet_pkg::OFFSET_COEF_OFFSET)
          s_axi_rdata <= 32'(offset_coef);
        else if (s_axi_araddr == refdet_pkg::GAIN_COEF_OFFSET)
          s_axi_rdata <= 32'(gain_coef);
        else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= refdet_pkg::RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // sticky flag: a new fault in the clearing cycle wins over the read
  always_ff @(posedge aclk) begin
    if (!aresetn) reference_missing_flag <= 1'b0;
    else if (ce) begin
      if (fault || (standby_exit && check_on))
        reference_missing_flag <= 1'b1;
      else if (err_read)
        reference_missing_flag <= 1'b0;
    end
  end

  // only one flag in this block, so the summary is that flag
  always_ff @(posedge aclk) begin
    if (!aresetn) status_err <= 1'b0;
    else if (ce) begin
      if (fault || (standby_exit && check_on)) status_err <= 1'b1;
      else if (err_read) status_err <= 1'b0;
    end
  end

  // the flag and a live fault both force, so the first bad sample is covered
  always_ff @(posedge aclk) begin
    if (!aresetn) result <= '0;
    else if (ce && conv_valid)
      result <= (reference_missing_flag || fault) ? '1 : conv_data;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      offset_coef <= DATA_W'(refdet_pkg::OFFSET_COEF_RESET);
      gain_coef <= DATA_W'(refdet_pkg::GAIN_COEF_RESET);
    end else if (ce && cal_done && !(reference_missing_flag || fault)) begin
      if (cal_is_gain) gain_coef <= cal_coef;
      else offset_coef <= cal_coef;
    end
  end

  // input routing; test pair switches only for the 20 mV source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_select <= refdet_pkg::SEL_INPUT_PAIR;
      test_signal_positive <= 1'b0;
      test_signal_negative <= 1'b0;
    end else if (ce) begin
      input_select <= sel;
      test_signal_positive <= (sel == refdet_pkg::SEL_TEST_SIGNAL);
      test_signal_negative <= (sel == refdet_pkg::SEL_TEST_SIGNAL);
    end
  end

  sequence s_fault_seen;
    ce && fault;
  endsequence

  a_flag_sticks: assert property (@(posedge aclk) disable iff (!aresetn)
    s_fault_seen |=> reference_missing_flag)
    else $error("flag not set after fault");

  a_status_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    status_err == reference_missing_flag)
    else $error("status error differs from flag");

  a_result_ones: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && conv_valid && reference_missing_flag) |=> (result == '1))
    else $error("result not forced to ones");

  a_coef_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && cal_done && reference_missing_flag) |=> $stable(offset_coef) && $stable(gain_coef))
    else $error("coefficient updated under fault");

  a_check_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    (!check_on && !$past(check_on)) |-> !fault)
    else $error("fault raised while check off");

  a_read_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && err_read && !fault && !(standby_exit && check_on)) |=> !reference_missing_flag)
    else $error("error read did not clear flag");

  a_flag_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (reference_missing_flag && !err_read) |=> reference_missing_flag)
    else $error("flag dropped without read");

  a_test_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && sel == refdet_pkg::SEL_TEST_SIGNAL) |=> test_signal_positive && test_signal_negative)
    else $error("test source not routed");

  a_standby_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && standby_exit && check_on) |=> reference_missing_flag)
    else $error("standby exit not flagged");
endmodule // reference_detect_diagnostics

// File: refdet_pkg.sv
package refdet_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] ERROR_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] RESULT_OFFSET = 8'h0C;
  localparam logic [7:0] OFFSET_COEF_OFFSET = 8'h10;
  localparam logic [7:0] GAIN_COEF_OFFSET = 8'h14;
  // control register fields
  localparam int CTRL_CHECK_EN_BIT = 0;
  localparam int CTRL_EXT_REF_BIT = 1;
  localparam int CTRL_INPUT_SEL_LSB = 4;
  localparam int INPUT_SEL_W = 3;
  // error and status fields
  localparam int ERROR_REF_MISSING_BIT = 0;
  localparam int STATUS_ERR_BIT = 0;
  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [23:0] OFFSET_COEF_RESET = 24'h80_0000;
  localparam logic [23:0] GAIN_COEF_RESET = 24'h50_0000;
  // minimum valid reference differential, millivolts
  localparam int REF_MIN_MV = 700;
  // internal test source amplitude, millivolts
  localparam int TEST_SIGNAL_MV = 20;
  // converter input source choices
  localparam logic [2:0] SEL_INPUT_PAIR = 3'h0;
  localparam logic [2:0] SEL_TEST_SIGNAL = 3'h1;
  localparam logic [2:0] SEL_REFERENCE = 3'h2;
  localparam logic [2:0] SEL_MAIN_SUPPLY = 3'h3;
  localparam logic [2:0] SEL_IO_SUPPLY = 3'h4;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: ref_monitor.sv
`timescale 1ns/1ns
// judges the sampled reference; pins come from another domain
module ref_monitor #(
  parameter int MV_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic check_on,
  input wire logic [MV_W-1:0] ref_diff_mv,
  input wire logic reference_input_positive_open,
  input wire logic reference_input_negative_open,
  output logic fault
);
  logic [1:0] open_p_sync;
  logic [1:0] open_n_sync;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_p_sync <= 2'h0;
      open_n_sync <= 2'h0;
    end else if (ce) begin
      open_p_sync <= {open_p_sync[0], reference_input_positive_open};
      open_n_sync <= {open_n_sync[0], reference_input_negative_open};
    end
  end

  // differential word comes from the converter core on this clock
  always_ff @(posedge aclk) begin
    if (!aresetn) fault <= 1'b0;
    else if (ce)
      fault <= check_on && ((ref_diff_mv < MV_W'(refdet_pkg::REF_MIN_MV)) ||
                            open_p_sync[1] || open_n_sync[1]);
  end
endmodule // ref_monitor

// File: reference_detect_diagnostics_bench.sv
`timescale 1ns/1ns
module reference_detect_diagnostics_bench;
  localparam logic [7:0] A_CTRL = refdet_pkg::CTRL_OFFSET;
  localparam logic [7:0] A_ERR = refdet_pkg::ERROR_OFFSET;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic ce = 1'h1;
  logic [3:0] wstrb = 4'hF;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [11:0] diff = 12'h9C4;
  logic popen = 1'h0, nopen = 1'h0, sbx = 1'h0, cv = 1'h0, cal = 1'h0, cg = 1'h0;
  logic [23:0] cdata = 24'h0, ccoef = 24'h0;
  wire awready, wready, bvalid, arready, rvalid, tsp, tsn, serr;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] isel;
  int err_count = 0;
  int comparisons = 0;
  logic [31:0] rd;
  logic [1:0] resp;

  always #25 aclk = ~aclk;

  reference_detect_diagnostics i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ref_diff_mv(diff), .reference_input_positive_open(popen),
    .reference_input_negative_open(nopen), .standby_exit(sbx), .conv_valid(cv),
    .conv_data(cdata), .cal_done(cal), .cal_is_gain(cg), .cal_coef(ccoef),
    .input_select(isel), .test_signal_positive(tsp), .test_signal_negative(tsn),
    .status_err(serr));

  task results();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task hang();
    $display("BAD wait expected answer seen none");
    err_count++;
    results();
  endtask

  task chkw(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task chkb(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask

  // both channels offered together, each dropped at its own handshake edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 40);
    if (bvalid !== 1'h1) hang();
    resp = bresp;
    bready <= 1'h0;
  endtask

  task rd_reg(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 40);
    if (rvalid !== 1'h1) hang();
    rd = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask

  // one strobe toward the converter-side inputs
  task core(input logic c, input logic k, input logic g, input logic [23:0] v);
    @(posedge aclk);
    cv <= c;
    cal <= k;
    cg <= g;
    cdata <= v;
    ccoef <= v;
    @(posedge aclk);
    cv <= 1'h0;
    cal <= 1'h0;
  endtask

  task t_reset();
    rd_reg(A_CTRL);
    chkw("ctrl", 32'h0, rd);
    chkb("status_err", 1'h0, serr);
    rd_reg(refdet_pkg::OFFSET_COEF_OFFSET);
    chkw("offset coef", 32'h0080_0000, rd);
    rd_reg(refdet_pkg::GAIN_COEF_OFFSET);
    chkw("gain coef", 32'h0050_0000, rd);
    rd_reg(8'h40);
    chkw("unmapped resp", {30'h0, refdet_pkg::RESP_SLVERR}, {30'h0, resp});
    wr(A_ERR, 32'h1);
    chkw("ro write resp", {30'h0, refdet_pkg::RESP_OKAY}, {30'h0, resp});
    wr(8'h40, 32'h1);
    chkw("unmapped write resp", {30'h0, refdet_pkg::RESP_SLVERR}, {30'h0, resp});
    $display("test reset done");
  endtask

  // fault applied, then removed before looking: the flag must have stuck
  task sense(input logic [31:0] c, input logic [11:0] d, input logic p, input logic m,
             input logic e);
    wr(A_CTRL, c);
    @(posedge aclk);
    diff <= d;
    popen <= p;
    nopen <= m;
    repeat (5) @(posedge aclk);
    diff <= 12'h9C4;
    popen <= 1'h0;
    nopen <= 1'h0;
    repeat (4) @(posedge aclk);
    chkb("status_err held", e, serr);
    rd_reg(A_ERR);
    chkw("error flag", {31'h0, e}, rd);
    repeat (2) @(posedge aclk);
    chkb("status_err cleared", 1'h0, serr);
    rd_reg(A_ERR);
    chkw("error after read", 32'h0, rd);
    $display("test sense ctrl %h diff %0d done", c, d);
  endtask

  task t_convcal();
    wr(A_CTRL, 32'h3);
    @(posedge aclk);
    diff <= 12'h064;
    core(1'h1, 1'h0, 1'h0, 24'h123456);
    rd_reg(refdet_pkg::RESULT_OFFSET);
    chkw("result faulted", 32'h00FF_FFFF, rd);
    rd_reg(A_ERR);
    chkw("flag on ones", 32'h1, rd);
    core(1'h0, 1'h1, 1'h1, 24'h111111);
    core(1'h0, 1'h1, 1'h0, 24'h111111);
    rd_reg(refdet_pkg::GAIN_COEF_OFFSET);
    chkw("gain kept", 32'h0050_0000, rd);
    rd_reg(refdet_pkg::OFFSET_COEF_OFFSET);
    chkw("offset kept", 32'h0080_0000, rd);
    rd_reg(A_ERR);
    chkw("flag after cal", 32'h1, rd);
    @(posedge aclk);
    diff <= 12'h9C4;
    repeat (3) @(posedge aclk);
    rd_reg(A_ERR);
    core(1'h1, 1'h1, 1'h1, 24'h222222);
    core(1'h0, 1'h1, 1'h0, 24'h333333);
    rd_reg(refdet_pkg::RESULT_OFFSET);
    chkw("result clean", 32'h0022_2222, rd);
    rd_reg(refdet_pkg::GAIN_COEF_OFFSET);
    chkw("gain loaded", 32'h0022_2222, rd);
    rd_reg(refdet_pkg::OFFSET_COEF_OFFSET);
    chkw("offset loaded", 32'h0033_3333, rd);
    $display("test conversion and calibration done");
  endtask

  // clock enable low: a fault present while frozen must not reach the flag until ce is high again
  task t_freeze();
    wr(A_CTRL, 32'h3);
    @(posedge aclk);
    ce <= 1'h0;
    diff <= 12'h064;
    repeat (4) @(posedge aclk);
    chkb("status_err frozen", 1'h0, serr);
    ce <= 1'h1;
    repeat (3) @(posedge aclk);
    chkb("status_err thawed", 1'h1, serr);
    diff <= 12'h9C4;
    repeat (3) @(posedge aclk);
    rd_reg(A_ERR);
    chkw("flag after freeze", 32'h1, rd);
    $display("test clock enable done");
  endtask

  task t_standby(input logic [31:0] c, input logic e);
    wr(A_CTRL, c);
    rd_reg(A_ERR);
    @(posedge aclk);
    sbx <= 1'h1;
    @(posedge aclk);
    sbx <= 1'h0;
    repeat (3) @(posedge aclk);
    chkb("status_err standby", e, serr);
    rd_reg(refdet_pkg::STATUS_OFFSET);
    chkw("status reg standby", {31'h0, e}, rd);
    rd_reg(A_ERR);
    chkw("standby flag", {31'h0, e}, rd);
    rd_reg(A_ERR);
    chkw("standby cleared", 32'h0, rd);
    $display("test standby ctrl %h done", c);
  endtask

  task t_route();
    for (int s = 0; s < 5; s++) begin
      wr(A_CTRL, 32'(s) << 4);
      repeat (2) @(posedge aclk);
      chkw("input_select", 32'(s), {29'h0, isel});
      chkb("test positive", s == 1, tsp);
      chkb("test negative", s == 1, tsn);
    end
    wstrb <= 4'hE;
    wr(A_CTRL, 32'h0);
    wstrb <= 4'hF;
    rd_reg(A_CTRL);
    chkw("ctrl readback", 32'h40, rd);
    $display("test routing done");
  endtask

  initial #4000000 hang();

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    t_reset();
    sense(32'h1, 12'h064, 1'h0, 1'h0, 1'h0);
    sense(32'h2, 12'h064, 1'h0, 1'h0, 1'h0);
    sense(32'h3, 12'h2BB, 1'h0, 1'h0, 1'h1);
    sense(32'h3, 12'h2BC, 1'h0, 1'h0, 1'h0);
    sense(32'h3, 12'h9C4, 1'h1, 1'h0, 1'h1);
    sense(32'h3, 12'h9C4, 1'h0, 1'h1, 1'h1);
    t_convcal();
    t_freeze();
    t_standby(32'h3, 1'h1);
    t_standby(32'h0, 1'h0);
    t_route();
    results();
  end
endmodule // reference_detect_diagnostics_bench
